/* hdl/msc_mode_config.sv */
// Three configuration registers of a 3-axis magnetic sensor plus trigger sequencing.
// Assumes an I2C target front end on ref_clk giving byte accesses, and a datapath reporting busy and done.
// How it works
// - Threshold form zero: each axis code is one signed threshold.
// - Threshold form one: low seven bits give equal north and south thresholds.
// - Operation bit 4 picks low current (0) or low noise (1).
// - Operation bit 3 zero keeps I2C glitch filter, one bypasses it.
// - Operation bit 2 picks I2C command bits or interrupt pin as trigger.
// - A trigger during a conversion waits until that conversion finishes.
// - Triggers arriving while one is pending or serviced are dropped.
// - Triggers are only honoured in standby.
// - Operation bits 1-0: standby, sleep, continuous, wake-up and sleep.
// - Leaving wake-up cycle for standby rewrites the mode field to standby.
// - Axis codes 0-7 are an X/Y/Z enable mask.
// - Axis codes 8-B give XYX, YXY, YZY, XZX sequences.
// - In wake-up cycle, sleep code sets the interval between conversions.
// - Crossing count bit: one or four crossings before interrupt.
// - Direction bit: above or below; ignored when form exceeds one.
// - Gain channel bit picks first or second axis of the angle pair.
// - Angle field enables angle, gain and offset on XY, YZ or XZ.
// - XY range bit doubles the X and Y full scale.
// - Z range bit doubles the Z full scale.
`timescale 1ns/1ps
module msc_mode_config
  import msc_pkg::*;
#(
  parameter int MS_CYCLES = MSC_MS_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register access from the I2C front end
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  // Conversion control
  input wire logic conv_cmd,
  input wire logic int_trig_pin_n,
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic ws_wake_exit,
  output logic conv_start,
  output logic continuous_run,
  output logic sleep_active,
  output logic ws_active,
  // Front end configuration
  output logic low_noise_en,
  output logic i2c_filter_bypass,
  output logic [2:0] axis_enable,
  output logic axis_seq_en,
  output logic [1:0] axis_seq_outer,
  output logic [1:0] axis_seq_middle,
  // Threshold configuration
  input wire logic [2:0][7:0] axis_threshold_code,
  output logic [2:0][7:0] thr_upper,
  output logic [2:0][7:0] thr_lower,
  output logic thr_dual_en,
  output logic [2:0] crossings_needed,
  output logic crossing_below,
  // Angle and range
  output logic angle_en,
  output logic [1:0] angle_first_axis,
  output logic [1:0] angle_second_axis,
  output logic gain_correction_channel,
  output logic xy_range_double,
  output logic z_range_double
);

  logic [1:0] rst_sync_r;
  logic rst_sync_n;
  logic [7:0] opctl_r;
  logic [7:0] chan_r;
  logic [6:0] thrs_r;
  logic [2:0] pin_sync_r;
  logic pin_fall;
  logic trig_evt;
  logic ws_wake;
  logic [1:0] op_mode;
  logic [2:0] thr_form;
  logic [3:0] axis_code;
  logic [1:0] ang_code;
  msc_trg_t trg_r;

  // ****************************************
  // Reset release
  // ****************************************
  // Two stages so release never lands near an edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_r[1];

  // ****************************************
  // Registers
  // ****************************************
  assign op_mode = opctl_r[OPC_MODE_HI:OPC_MODE_LO];
  assign thr_form = opctl_r[OPC_FORM_HI:OPC_FORM_LO];
  assign axis_code = chan_r[CHN_AXIS_HI:CHN_AXIS_LO];
  assign ang_code = thrs_r[THS_ANG_HI:THS_ANG_LO];

  // Host write wins over the automatic fall back to standby
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      opctl_r <= MSC_RST_OPCTL;
    end else if (reg_wr_en && reg_addr == MSC_OFS_OPCTL) begin
      opctl_r <= reg_wr_data;
    end else if (ws_wake_exit && op_mode == MSC_MODE_WAKE) begin
      opctl_r[OPC_MODE_HI:OPC_MODE_LO] <= MSC_MODE_STANDBY;
    end
  end
  // Channel and sleep setup
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chan_r <= MSC_RST_CHAN;
    end else if (reg_wr_en && reg_addr == MSC_OFS_CHAN) begin
      chan_r <= reg_wr_data;
    end
  end
  // Top bit is reserved and not stored
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      thrs_r <= MSC_RST_THRS;
    end else if (reg_wr_en && reg_addr == MSC_OFS_THRS) begin
      thrs_r <= reg_wr_data[THS_STORED_HI:0];
    end
  end
  // Read data registered; unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rd_data <= MSC_RD_ZERO;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        unique case (reg_addr)
          MSC_OFS_OPCTL: reg_rd_data <= opctl_r;
          MSC_OFS_CHAN: reg_rd_data <= chan_r;
          MSC_OFS_THRS: reg_rd_data <= {1'b0, thrs_r};
          default: reg_rd_data <= MSC_RD_ZERO;
        endcase
      end
    end
  end

  // ****************************************
  // Trigger path
  // ****************************************
  // Pin is asynchronous; third stage only feeds the edge detector
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_sync_r <= 3'h7;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], int_trig_pin_n};
    end
  end
  assign pin_fall = pin_sync_r[2] && !pin_sync_r[1];

  // Source select honoured only in standby
  assign trig_evt = (op_mode == MSC_MODE_STANDBY) &&
    ((opctl_r[OPC_TRIG] == MSC_TRIG_PIN) ? pin_fall : conv_cmd);

  // One trigger in flight; extra events simply fall away
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      trg_r <= MSC_TRG_IDLE;
    end else begin
      unique case (trg_r)
        MSC_TRG_IDLE: begin
          if (trig_evt) begin
            trg_r <= MSC_TRG_WAIT;
          end
        end
        MSC_TRG_WAIT: begin
          if (!conv_busy) begin
            trg_r <= MSC_TRG_RUN;
          end
        end
        MSC_TRG_RUN: begin
          if (conv_done) begin
            trg_r <= MSC_TRG_IDLE;
          end
        end
        default: trg_r <= MSC_TRG_IDLE;
      endcase
    end
  end
  // Wake-up interval timer
  msc_ws_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_ws_timer (
    .ref_clk(ref_clk),
    .rst_sync_n(rst_sync_n),
    .run(op_mode == MSC_MODE_WAKE),
    .interval_ms(msc_sleep_ms(chan_r[CHN_SLEEP_HI:CHN_SLEEP_LO])),
    .wake(ws_wake)
  );

  // Queued trigger starts once the running conversion is done
  assign conv_start = (trg_r == MSC_TRG_WAIT && !conv_busy) || ws_wake;
  assign continuous_run = (op_mode == MSC_MODE_CONT);
  assign sleep_active = (op_mode == MSC_MODE_SLEEP);
  assign ws_active = (op_mode == MSC_MODE_WAKE);

  // ****************************************
  // Configuration decode
  // ****************************************
  assign low_noise_en = opctl_r[OPC_NOISE];
  assign i2c_filter_bypass = opctl_r[OPC_FILT];
  assign thr_dual_en = (thr_form == MSC_FORM_DUAL);
  assign crossings_needed = thrs_r[THS_COUNT] ? MSC_CROSS_FOUR : MSC_CROSS_ONE;
  assign crossing_below = (thr_form <= MSC_FORM_DUAL) && thrs_r[THS_DIR];
  assign gain_correction_channel = thrs_r[THS_GAIN];
  assign xy_range_double = thrs_r[THS_XYR];
  assign z_range_double = thrs_r[THS_ZR];
  assign angle_en = (ang_code != MSC_ANG_OFF);

  // Reserved axis codes acquire nothing rather than guess
  always_comb begin
    axis_enable = 3'h0;
    axis_seq_en = 1'b0;
    axis_seq_outer = MSC_AXIS_X;
    axis_seq_middle = MSC_AXIS_X;
    if (axis_code <= MSC_AXIS_MASK_LAST) begin
      axis_enable = axis_code[2:0];
    end else if (axis_code <= MSC_AXIS_SEQ_LAST) begin
      axis_seq_en = 1'b1;
      unique case (axis_code[1:0])
        2'h0: begin
          axis_seq_outer = MSC_AXIS_X;
          axis_seq_middle = MSC_AXIS_Y;
        end
        2'h1: begin
          axis_seq_outer = MSC_AXIS_Y;
          axis_seq_middle = MSC_AXIS_X;
        end
        2'h2: begin
          axis_seq_outer = MSC_AXIS_Y;
          axis_seq_middle = MSC_AXIS_Z;
        end
        2'h3: begin
          axis_seq_outer = MSC_AXIS_X;
          axis_seq_middle = MSC_AXIS_Z;
        end
      endcase
      axis_enable = 3'(3'h1 << axis_seq_outer) | 3'(3'h1 << axis_seq_middle);
    end
  end

  // Angle pair; the off code still reports X then Y
  always_comb begin
    angle_first_axis = MSC_AXIS_X;
    angle_second_axis = MSC_AXIS_Y;
    unique case (ang_code)
      MSC_ANG_OFF, MSC_ANG_XY: begin
        angle_first_axis = MSC_AXIS_X;
        angle_second_axis = MSC_AXIS_Y;
      end
      MSC_ANG_YZ: begin
        angle_first_axis = MSC_AXIS_Y;
        angle_second_axis = MSC_AXIS_Z;
      end
      MSC_ANG_XZ: begin
        angle_first_axis = MSC_AXIS_X;
        angle_second_axis = MSC_AXIS_Z;
      end
    endcase
  end

  // ****************************************
  // Threshold shaping per axis
  // ****************************************
  // Reserved forms yield zero thresholds, which disable comparison
  for (genvar g = 0; g < MSC_AXES; g++) begin : g_axis
    logic [7:0] mag;
    assign mag = {1'b0, axis_threshold_code[g][6:0]};
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        thr_upper[g] <= MSC_RD_ZERO;
        thr_lower[g] <= MSC_RD_ZERO;
      end else if (thr_form == MSC_FORM_SINGLE) begin
        thr_upper[g] <= axis_threshold_code[g];
        thr_lower[g] <= axis_threshold_code[g];
      end else if (thr_form == MSC_FORM_DUAL) begin
        thr_upper[g] <= mag;
        thr_lower[g] <= ~mag + MSC_ONE8;
      end else begin
        thr_upper[g] <= MSC_RD_ZERO;
        thr_lower[g] <= MSC_RD_ZERO;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  mode_write_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    reg_wr_en && reg_addr == MSC_OFS_OPCTL |=> op_mode == $past(reg_wr_data[OPC_MODE_HI:OPC_MODE_LO]))
    else $error("mode field not taken from write");
  ws_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    ws_wake_exit && ws_active && !(reg_wr_en && reg_addr == MSC_OFS_OPCTL) |=> op_mode == MSC_MODE_STANDBY)
    else $error("wake exit did not return to standby");
  mode_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    trg_r == MSC_TRG_IDLE && op_mode != MSC_MODE_STANDBY |=> trg_r == MSC_TRG_IDLE)
    else $error("trigger taken outside standby");
  busy_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    trg_r == MSC_TRG_WAIT && conv_busy && !ws_wake |-> !conv_start ##1 trg_r == MSC_TRG_WAIT)
    else $error("trigger started over a running conversion");
  drop_extra_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    trg_r == MSC_TRG_RUN && !conv_done ##1 trg_r == MSC_TRG_RUN && !conv_busy && !ws_wake |-> !conv_start)
    else $error("second trigger started while serviced");
  src_cmd_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    trg_r == MSC_TRG_IDLE && !conv_cmd && opctl_r[OPC_TRIG] == MSC_TRIG_CMD |=> trg_r == MSC_TRG_IDLE)
    else $error("pin trigger taken in command mode");
  single_thr_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    thr_form == MSC_FORM_SINGLE |=> thr_upper[0] == $past(axis_threshold_code[0]))
    else $error("single threshold not the signed code");
  dual_thr_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    thr_form == MSC_FORM_DUAL |=> thr_upper[1] + thr_lower[1] == 8'h00 && !thr_upper[1][7])
    else $error("dual thresholds not opposite");
  dir_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    thr_form > MSC_FORM_DUAL |-> !crossing_below)
    else $error("direction honoured for reserved form");
  cross_count_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    reg_wr_en && reg_addr == MSC_OFS_THRS |=> crossings_needed == ($past(reg_wr_data[THS_COUNT]) ? 3'h4 : 3'h1))
    else $error("crossing count wrong");
  rsvd_read_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    reg_rd_en && reg_addr == MSC_OFS_THRS |=> reg_rd_valid && !reg_rd_data[7]
      && reg_rd_data[THS_GAIN] == $past(gain_correction_channel))
    else $error("threshold setup readback wrong");

endmodule : msc_mode_config

/* hdl/msc_pkg.sv */
// Constants, field layout and lookup helpers for the sensor mode configuration block.
// Assumes a 125 MHz single-clock system; shared by the register block and its sleep timer.
package msc_pkg;

  // ****************************************
  // Register offsets and reset values
  // ****************************************
  localparam logic [7:0] MSC_OFS_OPCTL = 8'h01;
  localparam logic [7:0] MSC_OFS_CHAN = 8'h02;
  localparam logic [7:0] MSC_OFS_THRS = 8'h03;
  localparam logic [7:0] MSC_RST_OPCTL = 8'h00;
  localparam logic [7:0] MSC_RST_CHAN = 8'h00;
  localparam logic [6:0] MSC_RST_THRS = 7'h00;
  localparam logic [7:0] MSC_RD_ZERO = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int OPC_FORM_HI = 7;
  localparam int OPC_FORM_LO = 5;
  localparam int OPC_NOISE = 4;
  localparam int OPC_FILT = 3;
  localparam int OPC_TRIG = 2;
  localparam int OPC_MODE_HI = 1;
  localparam int OPC_MODE_LO = 0;
  localparam int CHN_AXIS_HI = 7;
  localparam int CHN_AXIS_LO = 4;
  localparam int CHN_SLEEP_HI = 3;
  localparam int CHN_SLEEP_LO = 0;
  localparam int THS_COUNT = 6;
  localparam int THS_DIR = 5;
  localparam int THS_GAIN = 4;
  localparam int THS_ANG_HI = 3;
  localparam int THS_ANG_LO = 2;
  localparam int THS_XYR = 1;
  localparam int THS_ZR = 0;
  localparam int THS_STORED_HI = 6;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] MSC_MODE_STANDBY = 2'h0;
  localparam logic [1:0] MSC_MODE_SLEEP = 2'h1;
  localparam logic [1:0] MSC_MODE_CONT = 2'h2;
  localparam logic [1:0] MSC_MODE_WAKE = 2'h3;
  localparam logic [2:0] MSC_FORM_SINGLE = 3'h0;
  localparam logic [2:0] MSC_FORM_DUAL = 3'h1;
  localparam logic MSC_TRIG_CMD = 1'b0;
  localparam logic MSC_TRIG_PIN = 1'b1;
  localparam logic [3:0] MSC_AXIS_MASK_LAST = 4'h7;
  localparam logic [3:0] MSC_AXIS_SEQ_LAST = 4'hB;
  localparam logic [1:0] MSC_AXIS_X = 2'h0;
  localparam logic [1:0] MSC_AXIS_Y = 2'h1;
  localparam logic [1:0] MSC_AXIS_Z = 2'h2;
  localparam logic [1:0] MSC_ANG_OFF = 2'h0;
  localparam logic [1:0] MSC_ANG_XY = 2'h1;
  localparam logic [1:0] MSC_ANG_YZ = 2'h2;
  localparam logic [1:0] MSC_ANG_XZ = 2'h3;
  localparam logic [2:0] MSC_CROSS_ONE = 3'h1;
  localparam logic [2:0] MSC_CROSS_FOUR = 3'h4;
  localparam logic [7:0] MSC_ONE8 = 8'h01;
  localparam int MSC_AXES = 3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int MSC_CLK_PERIOD_NS = 8;
  localparam int MSC_MS_NS = 1000000;
  localparam int MSC_MS_CYCLES = MSC_MS_NS / MSC_CLK_PERIOD_NS;

  // Trigger sequencer states, Gray along idle-wait-run
  typedef enum logic [1:0] {
    MSC_TRG_IDLE = 2'h0,
    MSC_TRG_WAIT = 2'h1,
    MSC_TRG_RUN = 2'h3
  } msc_trg_t;

  // Sleep interval in ms; reserved codes take the longest interval
  function automatic logic [14:0] msc_sleep_ms(input logic [3:0] code);
    case (code)
      4'h0: msc_sleep_ms = 15'h0001;
      4'h1: msc_sleep_ms = 15'h0005;
      4'h2: msc_sleep_ms = 15'h000A;
      4'h3: msc_sleep_ms = 15'h000F;
      4'h4: msc_sleep_ms = 15'h0014;
      4'h5: msc_sleep_ms = 15'h001E;
      4'h6: msc_sleep_ms = 15'h0032;
      4'h7: msc_sleep_ms = 15'h0064;
      4'h8: msc_sleep_ms = 15'h01F4;
      4'h9: msc_sleep_ms = 15'h03E8;
      4'hA: msc_sleep_ms = 15'h07D0;
      4'hB: msc_sleep_ms = 15'h1388;
      default: msc_sleep_ms = 15'h4E20;
    endcase
  endfunction : msc_sleep_ms

endpackage : msc_pkg

/* hdl/msc_ws_timer.sv */
// Wake-up interval timer: a ms tick divider followed by a ms counter.
// Assumes run drops whenever the device is not cycling wake-up and sleep.
`timescale 1ns/1ps
module msc_ws_timer
  import msc_pkg::*;
#(
  parameter int MS_CYCLES = MSC_MS_CYCLES
) (
  // Clock and synchronised reset
  input wire logic ref_clk,
  input wire logic rst_sync_n,
  // Control
  input wire logic run,
  input wire logic [14:0] interval_ms,
  // Expiry pulse
  output logic wake
);

  localparam int DIV_W = $clog2(MS_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

  logic [DIV_W-1:0] div_r;
  logic [14:0] ms_r;
  logic tick;

  // ****************************************
  // Millisecond enable
  // ****************************************
  assign tick = run && (div_r == DIV_LAST);

  // Divider held at zero outside the cycle so each period starts clean
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_r <= '0;
    end else if (!run || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // ****************************************
  // Interval count
  // ****************************************
  assign wake = tick && (ms_r + 15'h0001 >= interval_ms);

  // Interval compared on every tick, so a new code takes effect in the current period
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ms_r <= '0;
    end else if (!run || wake) begin
      ms_r <= '0;
    end else if (tick) begin
      ms_r <= ms_r + 15'h0001;
    end
  end

endmodule : msc_ws_timer

/* testbench/msc_host_model.sv */
// Host controller stand-in: register strobes, trigger lines and a datapath echo.
// Assumes one bench process calls its tasks, each entered just after a rising edge.
`timescale 1ns/1ps
module msc_host_model (
  // Clock and start pulse seen from the block
  input wire logic ref_clk,
  input wire logic conv_start,
  // Register strobes
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid,
  // Trigger and datapath lines
  output logic conv_cmd,
  output logic int_trig_pin_n,
  output logic conv_busy,
  output logic conv_done,
  output logic ws_wake_exit
);
  logic auto_done;
  // Idle levels; the pin idles high as an active-low line
  initial begin
    {reg_wr_en, reg_rd_en, conv_cmd, conv_busy, conv_done, ws_wake_exit} = '0;
    {reg_addr, reg_wr_data} = 16'h0000;
    int_trig_pin_n = 1'b1;
    auto_done = 1'b1;
  end
  // Datapath echo: finishes every started conversion one cycle later
  always @(posedge ref_clk) begin
    if (auto_done && conv_start === 1'b1) begin
      #1 conv_done = 1'b1;
      @(posedge ref_clk) #1 conv_done = 1'b0;
    end
  end
  task automatic step;
    @(posedge ref_clk) #1;
  endtask : step
  // Released bus lines show the inverse, so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step();
    {reg_wr_en, reg_addr, reg_wr_data} = {1'b1, a, d};
    step();
    {reg_wr_en, reg_addr, reg_wr_data} = {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    step();
    {reg_rd_en, reg_addr} = {1'b1, a};
    step();
    {reg_rd_en, reg_addr} = {1'b0, ~a};
    d = reg_rd_data;
    ok = reg_rd_valid;
  endtask : rd
  task automatic cmd;
    step();
    conv_cmd = 1'b1;
    step();
    conv_cmd = 1'b0;
  endtask : cmd
  task automatic exit_ws;
    step();
    ws_wake_exit = 1'b1;
    step();
    ws_wake_exit = 1'b0;
  endtask : exit_ws
  task automatic done;
    step();
    {conv_done, conv_busy} = 2'b10;
    step();
    conv_done = 1'b0;
  endtask : done
endmodule : msc_host_model

/* testbench/tb_top.sv */
// Self-checking bench for the mode configuration registers and trigger path.
// Assumes the host model drives controller and datapath lines; ms tick cut to 10 cycles.
`timescale 1ns/1ps
module tb_top;
  import msc_pkg::*;
  localparam int MSCYC = 10;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, conv_cmd, int_trig_pin_n, conv_busy, conv_done, ws_wake_exit;
  logic conv_start, continuous_run, sleep_active, ws_active, low_noise_en, i2c_filter_bypass, axis_seq_en;
  logic thr_dual_en, crossing_below, angle_en, gain_correction_channel, xy_range_double, z_range_double;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic [2:0] axis_enable, crossings_needed;
  logic [1:0] axis_seq_outer, axis_seq_middle, angle_first_axis, angle_second_axis;
  logic [2:0][7:0] axis_threshold_code, thr_upper, thr_lower;
  int num_errors = 0;
  int samples_checked = 0;
  msc_mode_config #(.MS_CYCLES(MSCYC)) i_msc_mode_config (
    .ref_clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .reg_rd_valid,
    .conv_cmd, .int_trig_pin_n, .conv_busy, .conv_done, .ws_wake_exit, .conv_start, .continuous_run,
    .sleep_active, .ws_active, .low_noise_en, .i2c_filter_bypass, .axis_enable, .axis_seq_en,
    .axis_seq_outer, .axis_seq_middle, .axis_threshold_code, .thr_upper, .thr_lower, .thr_dual_en,
    .crossings_needed, .crossing_below, .angle_en, .angle_first_axis, .angle_second_axis,
    .gain_correction_channel, .xy_range_double, .z_range_double);
  msc_host_model i_msc_host_model (
    .ref_clk, .conv_start, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
    .reg_rd_valid, .conv_cmd, .int_trig_pin_n, .conv_busy, .conv_done, .ws_wake_exit);
  always #4 ref_clk = ~ref_clk;
  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic step;
    @(posedge ref_clk) #1;
  endtask : step
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_msc_host_model.rd(a, d, ok);
    chk({ok, d}, {1'b1, exp});
  endtask : rdchk
  // Bounded window: counts start pulses over n cycles
  task automatic starts(input int n, output int k);
    k = 0;
    repeat (n) begin
      if (conv_start === 1'b1) k++;
      step();
    end
  endtask : starts
  task automatic give_verdict;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rdchk(MSC_OFS_OPCTL, 8'h00);
    rdchk(MSC_OFS_CHAN, 8'h00);
    rdchk(MSC_OFS_THRS, 8'h00);
    rdchk(8'h04, 8'h00);
    chk({crossings_needed, axis_enable}, {MSC_CROSS_ONE, 3'h0});
  endtask : t_reset
  task automatic t_opctl;
    logic [7:0] d;
    for (int m = 0; m < 4; m++) begin
      d = {3'h0, m[0], m[1], 1'b0, m[1:0]};
      i_msc_host_model.wr(MSC_OFS_OPCTL, d);
      chk({low_noise_en, i2c_filter_bypass}, {m[0], m[1]});
      chk({ws_active, continuous_run, sleep_active}, {m == 3, m == 2, m == 1});
      rdchk(MSC_OFS_OPCTL, d);
    end
    i_msc_host_model.wr(MSC_OFS_OPCTL, 8'h00);
  endtask : t_opctl
  task automatic t_axis;
    logic [6:0] om;
    for (int c = 0; c < 16; c++) begin
      i_msc_host_model.wr(MSC_OFS_CHAN, {c[3:0], 4'h0});
      case (c)
        8: om = {MSC_AXIS_X, MSC_AXIS_Y, 3'h3};
        9: om = {MSC_AXIS_Y, MSC_AXIS_X, 3'h3};
        10: om = {MSC_AXIS_Y, MSC_AXIS_Z, 3'h6};
        default: om = {MSC_AXIS_X, MSC_AXIS_Z, 3'h5};
      endcase
      chk(axis_seq_en, c inside {[8:11]});
      if (c < 8 || c > 11) chk(axis_enable, (c < 8) ? c[2:0] : 3'h0);
      else chk({axis_seq_outer, axis_seq_middle, axis_enable}, om);
    end
  endtask : t_axis
  task automatic t_angle;
    logic [3:0] pr [4] = '{4'h0, {MSC_AXIS_X, MSC_AXIS_Y}, {MSC_AXIS_Y, MSC_AXIS_Z}, {MSC_AXIS_X, MSC_AXIS_Z}};
    i_msc_host_model.wr(MSC_OFS_THRS, 8'hFF);
    rdchk(MSC_OFS_THRS, 8'h7F);
    chk({crossings_needed, crossing_below, gain_correction_channel}, {MSC_CROSS_FOUR, 2'b11});
    chk({xy_range_double, z_range_double}, 2'b11);
    for (int a = 0; a < 4; a++) begin
      i_msc_host_model.wr(MSC_OFS_THRS, {4'h0, a[1:0], 2'b00});
      chk(angle_en, a != 0);
      if (a != 0) chk({angle_first_axis, angle_second_axis}, pr[a]);
    end
    chk({crossings_needed, crossing_below, gain_correction_channel, xy_range_double, z_range_double},
        {MSC_CROSS_ONE, 4'h0});
  endtask : t_angle
  task automatic t_thr;
    logic [7:0] cd [3] = '{8'h85, 8'h7F, 8'h01};
    logic [7:0] up, lo;
    axis_threshold_code = {cd[2], cd[1], cd[0]};
    i_msc_host_model.wr(MSC_OFS_THRS, 8'h20);
    for (int f = 0; f < 3; f++) begin
      i_msc_host_model.wr(MSC_OFS_OPCTL, {f[2:0], 5'h00});
      step();
      chk({thr_dual_en, crossing_below}, {f == 1, f < 2});
      for (int i = 0; i < 3; i++) begin
        up = (f == 0) ? cd[i] : (f == 1) ? {1'b0, cd[i][6:0]} : 8'h00;
        lo = (f == 0) ? up : 8'h00 - up;
        chk({thr_upper[i], thr_lower[i]}, {up, lo});
      end
    end
  endtask : t_thr
  // Datapath echo off here so busy and done are placed by hand
  task automatic t_trig;
    int k;
    i_msc_host_model.auto_done = 1'b0;
    i_msc_host_model.wr(MSC_OFS_OPCTL, 8'h00);
    i_msc_host_model.cmd();
    chk(conv_start, 1'b1);
    step();
    i_msc_host_model.conv_busy = 1'b1;
    i_msc_host_model.cmd();
    starts(4, k);
    chk(k, 0);
    i_msc_host_model.done();
    i_msc_host_model.conv_busy = 1'b1;
    i_msc_host_model.cmd();
    i_msc_host_model.cmd();
    starts(3, k);
    chk(k, 0);
    i_msc_host_model.conv_busy = 1'b0;
    #1 chk(conv_start, 1'b1);
    step();
    i_msc_host_model.conv_busy = 1'b1;
    starts(4, k);
    chk(k, 0);
    i_msc_host_model.done();
    i_msc_host_model.wr(MSC_OFS_OPCTL, 8'h04);
    i_msc_host_model.cmd();
    starts(4, k);
    chk(k, 0);
    i_msc_host_model.int_trig_pin_n = 1'b0;
    starts(8, k);
    chk(k, 1);
    i_msc_host_model.int_trig_pin_n = 1'b1;
    i_msc_host_model.done();
    i_msc_host_model.wr(MSC_OFS_OPCTL, 8'h05);
    i_msc_host_model.int_trig_pin_n = 1'b0;
    starts(8, k);
    chk(k, 0);
    i_msc_host_model.int_trig_pin_n = 1'b1;
    i_msc_host_model.wr(MSC_OFS_OPCTL, 8'h01);
    i_msc_host_model.cmd();
    starts(4, k);
    chk(k, 0);
    i_msc_host_model.auto_done = 1'b1;
  endtask : t_trig
  // Interval codes 0 and 1: 10 and 50 cycles with the shortened tick
  task automatic t_wake;
    int k;
    int exp [2] = '{3, 2};
    int len [2] = '{35, 105};
    for (int s = 0; s < 2; s++) begin
      i_msc_host_model.wr(MSC_OFS_OPCTL, 8'h00);
      i_msc_host_model.wr(MSC_OFS_CHAN, {4'h1, s[3:0]});
      i_msc_host_model.wr(MSC_OFS_OPCTL, {6'h00, MSC_MODE_WAKE});
      starts(len[s], k);
      chk(k, exp[s]);
    end
    i_msc_host_model.exit_ws();
    chk(ws_active, 1'b0);
    rdchk(MSC_OFS_OPCTL, 8'h00);
  endtask : t_wake
  // Main sequence: reset held 8 cycles, then 3 cycles before the first access
  initial begin
    axis_threshold_code = '0;
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (3) step();
    t_reset();
    t_opctl();
    t_axis();
    t_angle();
    t_thr();
    t_trig();
    t_wake();
    give_verdict();
  end
endmodule : tb_top
